// ---- design/ring_map_pkg.sv ----
// Constants shared by the ring service frame mapper and its helpers.
// Assumes a single byte-wide MAC clock domain.
package ring_map_pkg;
  // Header control byte layout and frame kind code.
  localparam logic [2:0] KIND_USER = 3'h1;
  localparam int CB_KIND = 0;
  localparam int CB_DIR = 3;
  localparam int CB_PROT = 4;
  localparam int CB_ELIG = 5;
  localparam int CB_TIER = 6;
  localparam int HDR_TOP = 96;
  localparam logic [3:0] HCS_IDX = 4'hD;
  localparam logic [1:0] FCS_LAST = 2'h3;
  localparam logic [2:0] DLY_FULL = 3'h4;
  // Service tiers and the fixed priorities they map to.
  localparam logic [1:0] TIER_LOW = 2'h0;
  localparam logic [1:0] TIER_MID = 2'h1;
  localparam logic [1:0] TIER_TOP = 2'h2;
  localparam logic [2:0] PRIO_LOW = 3'h0;
  localparam logic [2:0] PRIO_MID = 3'h4;
  localparam logic [2:0] PRIO_TOP = 3'h6;
  // Reflected CRC-32 parameters.
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  // Register map and control reset value.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_TXCNT = 12'h008;
  localparam logic [11:0] ADDR_RXCNT = 12'h00C;
  localparam logic [11:0] ADDR_ERRCNT = 12'h010;
  localparam int CTL_DIR = 0;
  localparam int CTL_PROT = 1;
  localparam int CTL_ELIG = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  // Reception outcome codes.
  localparam logic [1:0] OUT_OK = 2'h0;
  localparam logic [1:0] OUT_FCS = 2'h1;
  localparam logic [1:0] OUT_HDR = 2'h2;
  localparam logic [1:0] OUT_RUNT = 2'h3;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_HDR = 5'h02,
    TX_PAY = 5'h04,
    TX_FCS = 5'h08,
    TX_DRAIN = 5'h10
  } tx_st_t;
  typedef enum logic [1:0] {
    RX_HDR = 2'h1,
    RX_PAY = 2'h2
  } rx_st_t;
endpackage

// ---- design/crc32_byte.sv ----
// One byte step of the reflected CRC-32 used for the frame check.
// Purely combinational; the caller holds the running value.
`timescale 1ns/100ps
module crc32_byte (
  input wire logic [31:0] crc_i, // Running CRC before the byte.
  input wire logic [7:0] data_i, // Byte to fold in.
  output logic [31:0] crc_o // Running CRC after the byte.
);
  import ring_map_pkg::*;

  // Bitwise shift, least significant data bit first.
  always_comb begin
    logic [31:0] c;
    c = crc_i ^ {24'h000000, data_i};
    for (int b = 0; b < 8; b++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end
endmodule // crc32_byte

// ---- design/tier_map.sv ----
// Fixed translation between user priority and ring service tier.
// Constants only; nothing here is writable, so the mapping cannot drift.
`timescale 1ns/100ps
module tier_map (
  input wire logic [2:0] prio_i, // Request priority.
  input wire logic [1:0] tier_i, // Received tier bits.
  output logic [1:0] tier_o, // Tier for the request priority.
  output logic [2:0] prio_o // Priority for the received tier.
);
  import ring_map_pkg::*;

  // Priorities 0-3 low, 4-5 middle, 6-7 top.
  always_comb begin
    if (prio_i >= PRIO_TOP) begin
      tier_o = TIER_TOP;
    end else if (prio_i >= PRIO_MID) begin
      tier_o = TIER_MID;
    end else begin
      tier_o = TIER_LOW;
    end
  end

  // An unused tier code is reported as the lowest priority.
  always_comb begin
    unique case (tier_i)
      TIER_TOP: prio_o = PRIO_TOP;
      TIER_MID: prio_o = PRIO_MID;
      default: prio_o = PRIO_LOW;
    endcase
  end
endmodule // tier_map

// ---- design/ring_service_frame_mapper.sv ----
// Service mapping between a bridge relay client and a ring MAC port.
// Assumes byte streams on both sides, one clock, and an APB master.
`timescale 1ns/100ps
// Behaviour
// [RULE_01] Build whole ring frame on each request.
// [RULE_02] Split each received frame, then indicate it.
// [RULE_03] Only user-data frame kind accepted and encoded.
// [RULE_04] Action parameter implied, never encoded.
// [RULE_05] Client payload copied unchanged into frame.
// [RULE_06] Addresses carried as true end addresses.
// [RULE_07] Priority 0-3 low, 4-5 middle, 6-7 top.
// [RULE_08] Received tier gives priority 0, 4, 6.
// [RULE_09] Priority tier mapping is fixed hardware.
// [RULE_10] Requested ring direction used, else default.
// [RULE_11] Arrival direction reported with each indication.
// [RULE_12] Missing protection request gets default protection.
// [RULE_13] Eligibility mark for middle tier, else default.
// [RULE_14] Received eligibility bit reported with indication.
// [RULE_15] Reception outcome reported with each indication.
// [RULE_16] CRC-32 covers bytes after header checksum.
// [RULE_17] Frame check generated when client gives none.
module ring_service_frame_mapper #(
  parameter int CNT_W = 16
) (
  input wire logic clk_i, // 25 MHz clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic tx_req_valid_i, // Transmit request present.
  output logic tx_req_ready_o, // Request taken when both high.
  input wire logic [2:0] tx_kind_i, // Requested frame kind.
  input wire logic [47:0] tx_da_i, // Destination address.
  input wire logic [47:0] tx_sa_i, // Source address.
  input wire logic [2:0] tx_prio_i, // User priority.
  input wire logic tx_dir_vld_i, // Ring direction given.
  input wire logic tx_dir_i, // Requested ring direction.
  input wire logic tx_prot_vld_i, // Protection request given.
  input wire logic tx_prot_i, // Requested protection.
  input wire logic tx_mark_vld_i, // Eligibility mark given.
  input wire logic tx_mark_i, // Requested eligibility mark.
  input wire logic tx_fcs_vld_i, // Client supplies frame check.
  input wire logic [31:0] tx_fcs_i, // Client frame check value.
  input wire logic [7:0] tx_data_i, // Payload byte.
  input wire logic tx_data_valid_i, // Payload byte present.
  input wire logic tx_data_last_i, // Last payload byte.
  output logic tx_data_ready_o, // Payload byte taken.
  output logic [7:0] ring_tx_data_o, // Frame byte to ring.
  output logic ring_tx_valid_o, // Frame byte present.
  output logic ring_tx_last_o, // Last frame byte.
  output logic ring_tx_dir_o, // Ring direction of this frame.
  input wire logic ring_tx_ready_i, // Ring takes the byte.
  input wire logic [7:0] ring_rx_data_i, // Frame byte from ring.
  input wire logic ring_rx_valid_i, // Frame byte present.
  input wire logic ring_rx_last_i, // Last frame byte.
  input wire logic ring_rx_dir_i, // Direction it arrived on.
  output logic [7:0] rx_data_o, // Payload byte to client.
  output logic rx_data_valid_o, // Payload byte pulse.
  output logic rx_ind_valid_o, // Indication pulse at frame end.
  output logic [2:0] rx_kind_o, // Received frame kind.
  output logic [47:0] rx_da_o, // Received destination.
  output logic [47:0] rx_sa_o, // Received source.
  output logic [2:0] rx_prio_o, // Priority from tier bits.
  output logic rx_dir_o, // Arrival direction.
  output logic rx_elig_o, // Eligibility bit of header.
  output logic [1:0] rx_outcome_o, // Reception outcome.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr // APB error on unmapped address.
);
  import ring_map_pkg::*;

  if (CNT_W < 1 || CNT_W > 31) begin : g_bad_cnt
    $error("CNT_W must lie between 1 and 31");
  end

  typedef struct packed {
    tx_st_t tx_st;
    logic [3:0] tx_idx;
    logic [103:0] tx_hdr;
    logic [7:0] tx_hcs;
    logic tx_fcs_own;
    logic [31:0] tx_fcs_in;
    logic [31:0] tx_crc;
    logic o_valid;
    logic o_last;
    logic o_first;
    logic o_dir;
    logic [7:0] o_data;
    rx_st_t rx_st;
    logic [3:0] rx_idx;
    logic [103:0] rx_hdr;
    logic [7:0] rx_hcs;
    logic rx_dir;
    logic [2:0] rx_prio;
    logic rx_bad;
    logic [31:0] rx_dly;
    logic [2:0] rx_fill;
    logic [31:0] rx_crc;
    logic p_valid;
    logic [7:0] p_data;
    logic i_valid;
    logic [1:0] i_out;
    logic [2:0] ctl;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] err_cnt;
    logic [31:0] rdata;
    logic rerr;
  } state_t;

  state_t s;
  state_t next_s;
  logic [31:0] tx_crc_nx;
  logic [31:0] rx_crc_nx;
  logic [1:0] req_tier;
  logic [2:0] rx_tier_prio;
  logic adv;

  // The two CRC steps run on payload bytes only, never on the header.
  crc32_byte u_tx_crc (
    .crc_i(s.tx_crc),
    .data_i(tx_data_i),
    .crc_o(tx_crc_nx)
  ); // [RULE_16]
  crc32_byte u_rx_crc (
    .crc_i(s.rx_crc),
    .data_i(s.rx_dly[7:0]),
    .crc_o(rx_crc_nx)
  ); // [RULE_16]

  // Fixed priority translation; no register reaches it.
  tier_map u_map (
    .prio_i(tx_prio_i),
    .tier_i(ring_rx_data_i[CB_TIER+:2]),
    .tier_o(req_tier),
    .prio_o(rx_tier_prio)
  ); // [RULE_09]

  // The output byte register moves when empty or taken by the ring.
  assign adv = !s.o_valid || ring_tx_ready_i;
  assign tx_req_ready_o = (s.tx_st == TX_IDLE);
  assign tx_data_ready_o = (s.tx_st == TX_PAY && adv) ||
                           (s.tx_st == TX_DRAIN);
  assign ring_tx_data_o = s.o_data;
  assign ring_tx_valid_o = s.o_valid;
  assign ring_tx_last_o = s.o_last;
  assign ring_tx_dir_o = s.o_dir;
  assign rx_data_o = s.p_data;
  assign rx_data_valid_o = s.p_valid;
  assign rx_ind_valid_o = s.i_valid;
  assign rx_kind_o = s.rx_hdr[HDR_TOP+CB_KIND+:3];
  assign rx_da_o = s.rx_hdr[95:48]; // [RULE_06]
  assign rx_sa_o = s.rx_hdr[47:0]; // [RULE_06]
  assign rx_prio_o = s.rx_prio;
  assign rx_dir_o = s.rx_dir; // [RULE_11]
  assign rx_elig_o = s.rx_hdr[HDR_TOP+CB_ELIG]; // [RULE_14]
  assign rx_outcome_o = s.i_out; // [RULE_15]
  assign prdata = s.rdata;
  assign pslverr = s.rerr;
  assign pready = 1'b1;

  // Next-state logic for transmit, receive and the register slave.
  always_comb begin
    logic [7:0] ctrl;
    logic [31:0] fcs;
    logic [31:0] dly;
    logic [31:0] crc_fin;
    ctrl = 8'h00;
    fcs = 32'h00000000;
    dly = 32'h00000000;
    crc_fin = 32'h00000000;
    next_s = s;
    next_s.p_valid = 1'b0;
    next_s.i_valid = 1'b0;
    if (adv) begin
      next_s.o_valid = 1'b0;
      next_s.o_first = 1'b0;
      next_s.o_last = 1'b0;
    end

    // Transmit: request, header, payload, check sequence.
    unique case (s.tx_st)
      TX_IDLE: begin
        if (tx_req_valid_i) begin
          ctrl[CB_KIND+:3] = tx_kind_i; // [RULE_03]
          ctrl[CB_TIER+:2] = req_tier; // [RULE_07]
          ctrl[CB_DIR] = tx_dir_vld_i ? tx_dir_i :
                         s.ctl[CTL_DIR]; // [RULE_10]
          ctrl[CB_PROT] = tx_prot_vld_i ? tx_prot_i :
                          s.ctl[CTL_PROT]; // [RULE_12]
          ctrl[CB_ELIG] = (req_tier == TIER_MID) &&
            (tx_mark_vld_i ? tx_mark_i : s.ctl[CTL_ELIG]); // [RULE_13]
          // Addresses go out exactly as given; no action field exists.
          next_s.tx_hdr = {ctrl, tx_da_i, tx_sa_i}; // [RULE_06] [RULE_04]
          next_s.tx_fcs_own = tx_fcs_vld_i;
          next_s.tx_fcs_in = tx_fcs_i;
          next_s.tx_crc = CRC_INIT;
          next_s.tx_hcs = 8'h00;
          next_s.tx_idx = 4'h0;
          // A foreign frame kind is swallowed along with its payload.
          if (tx_kind_i == KIND_USER) begin
            next_s.tx_st = TX_HDR; // [RULE_01]
          end else begin
            next_s.tx_st = TX_DRAIN; // [RULE_03]
            next_s.err_cnt = s.err_cnt + 1'b1;
          end
        end
      end
      TX_HDR: begin
        if (adv) begin
          next_s.o_valid = 1'b1;
          next_s.o_first = (s.tx_idx == 4'h0);
          if (s.tx_idx == 4'h0) begin
            next_s.o_dir = s.tx_hdr[HDR_TOP+CB_DIR]; // [RULE_10]
          end
          if (s.tx_idx == HCS_IDX) begin
            next_s.o_data = s.tx_hcs;
            next_s.tx_st = TX_PAY;
          end else begin
            next_s.o_data = s.tx_hdr[103:96]; // [RULE_01]
            next_s.tx_hcs = s.tx_hcs ^ s.tx_hdr[103:96];
            next_s.tx_hdr = {s.tx_hdr[95:0], 8'h00};
            next_s.tx_idx = s.tx_idx + 4'h1;
          end
        end
      end
      TX_PAY: begin
        if (adv && tx_data_valid_i) begin
          next_s.o_valid = 1'b1;
          next_s.o_data = tx_data_i; // [RULE_05]
          next_s.tx_crc = tx_crc_nx; // [RULE_16]
          if (tx_data_last_i) begin
            next_s.tx_st = TX_FCS;
            next_s.tx_idx = 4'h0;
          end
        end
      end
      TX_FCS: begin
        // Client value wins; otherwise our own CRC, low byte first.
        fcs = s.tx_fcs_own ? s.tx_fcs_in : ~s.tx_crc; // [RULE_17]
        fcs = fcs >> {s.tx_idx[1:0], 3'b000};
        if (adv) begin
          next_s.o_valid = 1'b1;
          next_s.o_data = fcs[7:0];
          next_s.o_last = (s.tx_idx[1:0] == FCS_LAST);
          next_s.tx_idx = s.tx_idx + 4'h1;
          if (s.tx_idx[1:0] == FCS_LAST) begin
            next_s.tx_st = TX_IDLE;
            next_s.tx_cnt = s.tx_cnt + 1'b1;
          end
        end
      end
      TX_DRAIN: begin
        if (tx_data_valid_i && tx_data_last_i) begin
          next_s.tx_st = TX_IDLE;
        end
      end
    endcase

    // Receive: header capture, then payload through a 4-byte delay
    // so the trailing check sequence never reaches the client.
    if (ring_rx_valid_i) begin
      unique case (s.rx_st)
        RX_HDR: begin
          if (s.rx_idx == 4'h0) begin
            next_s.rx_dir = ring_rx_dir_i; // [RULE_11]
            next_s.rx_prio = rx_tier_prio; // [RULE_08]
            next_s.rx_hcs = 8'h00;
          end
          if (s.rx_idx == HCS_IDX) begin
            next_s.rx_bad = (ring_rx_data_i != s.rx_hcs) ||
              (s.rx_hdr[HDR_TOP+CB_KIND+:3] != KIND_USER); // [RULE_03]
            next_s.rx_st = RX_PAY;
            next_s.rx_fill = 3'h0;
            next_s.rx_crc = CRC_INIT;
          end else begin
            next_s.rx_hdr = {s.rx_hdr[95:0], ring_rx_data_i};
            next_s.rx_hcs = (s.rx_idx == 4'h0) ? ring_rx_data_i :
                            (s.rx_hcs ^ ring_rx_data_i);
            next_s.rx_idx = s.rx_idx + 4'h1;
          end
          // A frame ending inside its header is still indicated.
          if (ring_rx_last_i) begin
            next_s.i_valid = 1'b1; // [RULE_02]
            next_s.i_out = OUT_RUNT; // [RULE_15]
            // Builds on the error count as transmit left it, so a same-cycle reject is kept.
            next_s.err_cnt = next_s.err_cnt + 1'b1;
            next_s.rx_st = RX_HDR;
            next_s.rx_idx = 4'h0;
          end
        end
        RX_PAY: begin
          dly = {ring_rx_data_i, s.rx_dly[31:8]};
          crc_fin = s.rx_crc;
          if (s.rx_fill == DLY_FULL) begin
            next_s.p_valid = 1'b1;
            next_s.p_data = s.rx_dly[7:0]; // [RULE_02]
            next_s.rx_crc = rx_crc_nx; // [RULE_16]
            crc_fin = rx_crc_nx;
          end else begin
            next_s.rx_fill = s.rx_fill + 3'h1;
          end
          next_s.rx_dly = dly;
          if (ring_rx_last_i) begin
            next_s.i_valid = 1'b1; // [RULE_02]
            next_s.rx_st = RX_HDR;
            next_s.rx_idx = 4'h0;
            if (s.rx_fill < DLY_FULL - 3'h1) begin
              next_s.i_out = OUT_RUNT;
            end else if (s.rx_bad) begin
              next_s.i_out = OUT_HDR;
            end else if (dly != ~crc_fin) begin
              next_s.i_out = OUT_FCS; // [RULE_16]
            end else begin
              next_s.i_out = OUT_OK; // [RULE_15]
            end
            if (next_s.i_out == OUT_OK) begin
              next_s.rx_cnt = s.rx_cnt + 1'b1;
            end else begin
              next_s.err_cnt = next_s.err_cnt + 1'b1;
            end
          end
        end
      endcase
    end

    // APB: read data and error are latched in the setup cycle, so the
    // access phase always completes in one cycle.
    if (psel && !penable) begin
      next_s.rerr = 1'b0;
      unique case (paddr)
        ADDR_CTRL: next_s.rdata = {29'h00000000, s.ctl};
        ADDR_STAT: next_s.rdata = {29'h00000000, s.o_valid,
                                   s.rx_st == RX_PAY, s.tx_st != TX_IDLE};
        ADDR_TXCNT: next_s.rdata = {{(32-CNT_W){1'b0}}, s.tx_cnt};
        ADDR_RXCNT: next_s.rdata = {{(32-CNT_W){1'b0}}, s.rx_cnt};
        ADDR_ERRCNT: next_s.rdata = {{(32-CNT_W){1'b0}}, s.err_cnt};
        default: begin
          next_s.rdata = 32'h00000000;
          next_s.rerr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
      next_s.ctl = pwdata[2:0];
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.tx_st <= TX_IDLE;
      s.rx_st <= RX_HDR;
      s.ctl <= CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  chk_req_to_hdr: // [RULE_01]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_req_valid_i && tx_req_ready_o && tx_kind_i == KIND_USER)
    |=> (s.tx_st == TX_HDR) ##1 (s.tx_st != TX_IDLE))
    else $error("request did not start a frame");
  chk_kind_reject: // [RULE_03]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_req_valid_i && tx_req_ready_o && tx_kind_i != KIND_USER)
    |=> s.tx_st == TX_DRAIN && !tx_req_ready_o)
    else $error("foreign frame kind not rejected");
  chk_kind_field: // [RULE_03]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (ring_tx_valid_o && s.o_first)
    |-> ring_tx_data_o[CB_KIND+:3] == KIND_USER)
    else $error("first byte lacks user frame kind");
  chk_pay_pass: // [RULE_05]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (s.tx_st == TX_PAY && tx_data_valid_i && tx_data_ready_o)
    |=> ring_tx_valid_o && ring_tx_data_o == $past(tx_data_i))
    else $error("payload byte not passed unchanged");
  chk_tier_tx: // [RULE_07]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_req_valid_i && tx_req_ready_o) |=>
    s.tx_hdr[HDR_TOP+CB_TIER+:2] ==
    (($past(tx_prio_i) >= 3'h6) ? TIER_TOP :
     ($past(tx_prio_i) >= 3'h4) ? TIER_MID : TIER_LOW))
    else $error("priority mapped to wrong tier");
  chk_tier_rx: // [RULE_08]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (ring_rx_valid_i && s.rx_st == RX_HDR && s.rx_idx == 4'h0)
    |=> rx_prio_o == (($past(ring_rx_data_i[7:6]) == TIER_TOP) ? 3'h6 :
        ($past(ring_rx_data_i[7:6]) == TIER_MID) ? 3'h4 : 3'h0))
    else $error("tier mapped to wrong priority");
  chk_ind_on_last: // [RULE_02]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (ring_rx_valid_i && ring_rx_last_i) |=> rx_ind_valid_o ##1
    !rx_ind_valid_o || $past(ring_rx_valid_i && ring_rx_last_i))
    else $error("frame end without indication");
  chk_dir_pick: // [RULE_10]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_req_valid_i && tx_req_ready_o) |=>
    s.tx_hdr[HDR_TOP+CB_DIR] == ($past(tx_dir_vld_i) ?
    $past(tx_dir_i) : $past(s.ctl[CTL_DIR])))
    else $error("wrong ring direction chosen");
  chk_elig_mid: // [RULE_13]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (s.tx_st == TX_HDR && s.tx_idx == 4'h0 && s.tx_hdr[HDR_TOP+CB_ELIG])
    |-> s.tx_hdr[HDR_TOP+CB_TIER+:2] == TIER_MID)
    else $error("eligibility set outside middle tier");
  // Checked where the last byte is loaded, since the next request may
  // overwrite the held client value while that byte still waits.
  chk_fcs_own: // [RULE_17]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (s.tx_st == TX_FCS && adv && s.tx_idx[1:0] == FCS_LAST &&
     s.tx_fcs_own) |=> ring_tx_data_o == $past(s.tx_fcs_in[31:24]))
    else $error("client check sequence not sent");
  chk_prot_pick: // [RULE_12]
  assert property (@(posedge clk_i) disable iff (rst_i)
    (tx_req_valid_i && tx_req_ready_o) |=>
    s.tx_hdr[HDR_TOP+CB_PROT] == ($past(tx_prot_vld_i) ?
    $past(tx_prot_i) : $past(s.ctl[CTL_PROT])))
    else $error("wrong protection choice");
endmodule // ring_service_frame_mapper

// ---- tb/ring_loop_model.sv ----
// Far-side ring model: loops each accepted frame byte back as received.
// Assumes the mapper's byte streams and one shared clock.
`timescale 1ns/100ps
module ring_loop_model (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic [7:0] tx_data_i, // Frame byte from mapper.
  input wire logic tx_valid_i, // Frame byte present.
  input wire logic tx_last_i, // Last frame byte.
  input wire logic tx_dir_i, // Ring direction of the frame.
  output logic tx_ready_o = 1'b0, // Ring takes the byte.
  output logic [7:0] rx_data_o = 8'h00, // Byte back to mapper.
  output logic rx_valid_o = 1'b0, // Byte present.
  output logic rx_last_o = 1'b0, // Last byte.
  output logic rx_dir_o = 1'b0 // Arrival direction.
);
  int seed = 85;
  // Ready stalls at random so slow and prompt answers both occur.
  // Idle data toggles so a stale byte can never pass for a real one.
  always @(posedge clk_i) begin
    tx_ready_o <= !rst_i && (($random(seed) & 3) != 0);
    rx_valid_o <= !rst_i && tx_valid_i && tx_ready_o;
    rx_last_o <= tx_valid_i && tx_ready_o && tx_last_i;
    rx_data_o <= (tx_valid_i && tx_ready_o) ? tx_data_i : ~rx_data_o;
    rx_dir_o <= tx_dir_i;
  end
endmodule // ring_loop_model

// ---- tb/testbench.sv ----
// Self-checking bench: frames loop through the ring model back to the
// receive side; expected indications and payload wait in queues.
`timescale 1ns/100ps
module testbench;
  import ring_map_pkg::*;
  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [2:0] pr;
    logic dir;
    logic elig;
    logic [1:0] oc;
  } ind_t;
  logic clk_i = 1'b0, rst_i = 1'b1, tx_req_valid_i = 1'b0;
  logic [2:0] tx_kind_i = 3'h0, tx_prio_i = 3'h0, ctrl = CTRL_RST;
  logic [47:0] tx_da_i = 48'h0, tx_sa_i = 48'h0, rx_da_o, rx_sa_o;
  logic tx_dir_vld_i = 1'b0, tx_dir_i = 1'b0, tx_prot_vld_i = 1'b0;
  logic tx_prot_i = 1'b0, tx_mark_vld_i = 1'b0, tx_mark_i = 1'b0;
  logic tx_fcs_vld_i = 1'b0, tx_data_valid_i = 1'b0, tx_data_last_i = 1'b0;
  logic [31:0] tx_fcs_i = 32'h0, pwdata = 32'h0, prdata, r;
  logic [7:0] tx_data_i = 8'h00, ring_tx_data_o, ring_rx_data_i, rx_data_o;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic tx_req_ready_o, tx_data_ready_o, ring_tx_valid_o, ring_tx_last_o;
  logic ring_tx_dir_o, ring_tx_ready_i, ring_rx_valid_i, ring_rx_last_i;
  logic ring_rx_dir_i, rx_data_valid_o, rx_ind_valid_o, rx_dir_o, rx_elig_o;
  logic [2:0] rx_kind_o, rx_prio_o;
  logic [1:0] rx_outcome_o;
  int seed = 85, err_total = 0, total_checks = 0, cyc = 0;
  ind_t ind_q[$];
  ind_t x;
  logic [7:0] pay_q[$];

  ring_service_frame_mapper dut (.clk_i, .rst_i, .tx_req_valid_i,
    .tx_req_ready_o, .tx_kind_i, .tx_da_i, .tx_sa_i, .tx_prio_i,
    .tx_dir_vld_i, .tx_dir_i, .tx_prot_vld_i, .tx_prot_i, .tx_mark_vld_i,
    .tx_mark_i, .tx_fcs_vld_i, .tx_fcs_i, .tx_data_i, .tx_data_valid_i,
    .tx_data_last_i, .tx_data_ready_o, .ring_tx_data_o, .ring_tx_valid_o,
    .ring_tx_last_o, .ring_tx_dir_o, .ring_tx_ready_i, .ring_rx_data_i,
    .ring_rx_valid_i, .ring_rx_last_i, .ring_rx_dir_i, .rx_data_o,
    .rx_data_valid_o, .rx_ind_valid_o, .rx_kind_o, .rx_da_o, .rx_sa_o,
    .rx_prio_o, .rx_dir_o, .rx_elig_o, .rx_outcome_o, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  ring_loop_model far (.clk_i(clk_i), .rst_i(rst_i),
    .tx_data_i(ring_tx_data_o), .tx_valid_i(ring_tx_valid_o),
    .tx_last_i(ring_tx_last_o), .tx_dir_i(ring_tx_dir_o),
    .tx_ready_o(ring_tx_ready_i), .rx_data_o(ring_rx_data_i),
    .rx_valid_o(ring_rx_valid_i), .rx_last_o(ring_rx_last_i),
    .rx_dir_o(ring_rx_dir_i));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never rewrites psel at once.
    @(posedge clk_i);
  endtask

  // Sends one request; bits of v/o: 0 direction, 1 mark, 2 client check.
  // Bit 0 of v also gives the protection request and bit 2 of o its value; bit 2 of o also makes the client check good.
  task automatic send(input logic [2:0] k, input logic [2:0] p,
    input logic [2:0] v, input logic [2:0] o, input int n);
    logic [47:0] da;
    logic [47:0] sa;
    logic mid;
    logic [7:0] b;
    logic [7:0] pb [8];
    logic [31:0] c;
    da = {16'($random(seed)), 32'($random(seed))};
    sa = {16'($random(seed)), 32'($random(seed))};
    mid = (p == 3'h4) || (p == 3'h5);
    // Independent reference check sequence over the payload, bit by bit.
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      pb[i] = 8'($random(seed));
      c = c ^ {24'h0, pb[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    if (k === KIND_USER) ind_q.push_back({da, sa, p < 3'h4 ? PRIO_LOW :
      mid ? PRIO_MID : PRIO_TOP, v[0] ? o[0] : ctrl[0],
      mid & (v[1] ? o[1] : ctrl[2]), (v[2] && !o[2]) ? OUT_FCS : OUT_OK});
    tx_req_valid_i <= 1'b1;
    tx_kind_i <= k;
    tx_da_i <= da;
    tx_sa_i <= sa;
    tx_prio_i <= p;
    {tx_dir_vld_i, tx_mark_vld_i, tx_fcs_vld_i} <= {v[0], v[1], v[2]};
    {tx_dir_i, tx_mark_i} <= {o[0], o[1]};
    {tx_prot_vld_i, tx_prot_i} <= {v[0], o[2]};
    tx_fcs_i <= o[2] ? ~c : 32'h0;
    do @(posedge clk_i); while (tx_req_ready_o !== 1'b1);
    tx_req_valid_i <= 1'b0;
    for (int i = 0; i < n; i++) begin
      b = pb[i];
      if (k === KIND_USER) pay_q.push_back(b);
      tx_data_i <= b;
      tx_data_valid_i <= 1'b1;
      tx_data_last_i <= (i == n - 1);
      do @(posedge clk_i); while (tx_data_ready_o !== 1'b1);
    end
    tx_data_valid_i <= 1'b0;
  endtask

  // Outputs are settled by the falling edge; compare against oldest note.
  always @(negedge clk_i) begin
    if (rx_data_valid_o === 1'b1) begin
      if (pay_q.size() == 0) check(1, 0);
      else check(rx_data_o, pay_q.pop_front());
    end
    if (rx_ind_valid_o === 1'b1) begin
      if (ind_q.size() == 0) check(1, 0);
      else begin
        x = ind_q.pop_front();
        check(rx_kind_o, KIND_USER);
        check({rx_da_o, rx_sa_o}, {x.da, x.sa});
        check(rx_prio_o, x.pr);
        check(rx_dir_o, x.dir);
        check(rx_elig_o, x.elig);
        check(rx_outcome_o, x.oc);
      end
    end
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check({r, e}, {29'h0, CTRL_RST, 1'b0});
    apb(1'b0, 12'h020, 32'h0);
    check({r, e}, {32'h0, 1'b1});
    for (int p = 0; p < 8; p++) begin
      send(KIND_USER, 3'(p), 3'h3, 3'(p), p + 1);
    end
    apb(1'b1, ADDR_CTRL, 32'h5);
    ctrl = 3'h5;
    send(KIND_USER, 3'h4, 3'h0, 3'h0, 1);
    send(KIND_USER, 3'h5, 3'h2, 3'h0, 2);
    send(3'h2, 3'h6, 3'h0, 3'h0, 3);
    send(KIND_USER, 3'h6, 3'h4, 3'h0, 4);
    send(KIND_USER, 3'h7, 3'h4, 3'h4, 3);
    send(KIND_USER, 3'h0, 3'h0, 3'h0, 5);
    for (int i = 0; i < 2000 && ind_q.size() > 0; i++) @(posedge clk_i);
    check(ind_q.size() + pay_q.size(), 0);
    // One rejected kind and one bad client check; 13 sent, 12 good.
    apb(1'b0, ADDR_ERRCNT, 32'h0);
    check(r, 32'h2);
    apb(1'b0, ADDR_TXCNT, 32'h0);
    check(r, 32'hD);
    apb(1'b0, ADDR_RXCNT, 32'h0);
    check(r, 32'hC);
    print_verdict;
  end
endmodule // testbench
